/* File: inc/elsb_pkg.sv */
// Purpose: shared types and constants for external bus lane steering
// Assumes: 32-bit external data bus, four byte lanes
// Notes: widths and endian encodings used by the steering core
package elsb_pkg;
  localparam int ELSB_LANES = 4;
  localparam int ELSB_DATA_W = 32;
  localparam logic ELSB_ENDIAN_RESET = 1'h0;
  localparam logic ELSB_ENDIAN_BIG = 1'h0;
  localparam logic [1:0] ELSB_STEP_RESET = 2'h0;

  // --------------------------------
  // access sizes and device widths
  // --------------------------------
  typedef enum logic [1:0] {ELSB_SZ_BYTE = 2'h0, ELSB_SZ_WORD = 2'h1, ELSB_SZ_LONG = 2'h2} elsb_size_t;
  typedef enum logic [1:0] {ELSB_DW_8 = 2'h0, ELSB_DW_16 = 2'h1, ELSB_DW_32 = 2'h2} elsb_dwidth_t;

  // --------------------------------
  // carriers
  // --------------------------------
  typedef struct packed {
    logic [31:0] addr;
    elsb_size_t size;
    elsb_dwidth_t dwidth;
    logic write;
    logic [31:0] wdata;
  } elsb_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [31:0] wdata;
    logic [3:0] strobe;
  } elsb_beat_t;
endpackage

/* File: core/elsb_lane_map.sv */
// Purpose: computes lane placement and strobes for one beat of a split access
// Assumes: combinational, same clock domain as caller
// Notes: step selects which piece of the original access is carried
`timescale 1ns/1ps
module elsb_lane_map
  import elsb_pkg::*;
(
  // request
  input wire elsb_size_t size,
  input wire elsb_dwidth_t dwidth,
  input wire logic big_endian,
  input wire logic [1:0] base_low,
  input wire logic [1:0] step,
  // placement
  output logic [1:0] beat_low,
  output logic [3:0] strobe,
  output logic [1:0] lane_of_byte0,
  output logic [1:0] pieces_minus1
);
  logic [1:0] nbytes_m1;
  logic [1:0] unit_m1;
  logic [1:0] blk;
  always_comb begin
    nbytes_m1 = (size == ELSB_SZ_BYTE) ? 2'h0 : (size == ELSB_SZ_WORD) ? 2'h1 : 2'h3;
    unit_m1 = (dwidth == ELSB_DW_8) ? 2'h0 : (dwidth == ELSB_DW_16) ? 2'h1 : 2'h3;
    // pieces needed when device is narrower than the access
    pieces_minus1 = (nbytes_m1 > unit_m1) ?
      ((unit_m1 == 2'h0) ? nbytes_m1 : 2'h1) : 2'h0;
    // address of this beat: ascending addresses
    beat_low = base_low + ((unit_m1 == 2'h0) ? step : {step[0], 1'h0});
    blk = (nbytes_m1 > unit_m1) ? unit_m1 : nbytes_m1;
    strobe = 4'h0;
    lane_of_byte0 = 2'h0;
    case (dwidth)
      ELSB_DW_8: begin
        strobe = 4'h1; // see RQ2 see RQ7
        lane_of_byte0 = 2'h0;
      end
      ELSB_DW_16: begin
        strobe = (blk == 2'h0) ? (4'h1 << {1'h0, (big_endian ^ beat_low[0])}) : 4'h3; // see RQ1
        lane_of_byte0 = {1'h0, (big_endian ^ beat_low[0])};
      end
      default: begin
        lane_of_byte0 = big_endian ? ~beat_low : beat_low; // see RQ3 see RQ6
        if (blk == 2'h0) begin
          strobe = 4'h1 << lane_of_byte0;
        end else if (blk == 2'h1) begin
          strobe = beat_low[1] ? 4'hC : 4'h3; // see RQ4
          strobe = big_endian ? {strobe[1:0], strobe[3:2]} : strobe;
        end else begin
          strobe = 4'hF; // see RQ5
        end
      end
    endcase
  end
endmodule

/* File: core/elsb_core.sv */
// Purpose: steers processor transfers onto the external data bus and splits them
// Assumes: one processor request at a time, ext_ready from same clock domain
// Notes: endian mode is caught from the strap pin after reset release
`timescale 1ns/1ps
// Overview of operation
// RQ1: 16-bit big-endian longword: two halves, high first
// RQ2: 8-bit big-endian: lane zero, MSB first
// RQ3: 32-bit little-endian byte uses its own lane
// RQ4: 32-bit little-endian word picks low/high half
// RQ5: 32-bit little-endian longword: one access, all strobes
// RQ6: 32-bit big-endian: address zero on top lane
// RQ7: 8-bit little-endian: lane zero, LSB first
// RQ8: endian latched from strap at reset; high=little
// RQ9: split beats back to back, one answer
module elsb_core
  import elsb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clock_en,
  // strap
  input wire logic endian_select_pin,
  // processor side
  input wire logic req_valid,
  input wire elsb_req_t req,
  output logic req_ready,
  output logic resp_valid,
  output logic [31:0] resp_rdata,
  // external side
  output logic ext_valid,
  output elsb_beat_t ext_beat,
  input wire logic ext_ready,
  input wire logic [31:0] ext_rdata,
  // status
  output logic big_endian
);
  typedef enum {ELSB_IDLE, ELSB_BUSY, ELSB_DONE} elsb_state_t;
  elsb_state_t state_reg;
  elsb_req_t req_reg;
  logic [1:0] step_reg;
  logic [31:0] rdata_reg;
  logic [1:0] strap_sync_reg;
  logic strap_taken_reg;
  logic big_endian_reg;
  logic [1:0] beat_low;
  logic [3:0] strobe;
  logic [1:0] lane0;
  logic [1:0] last_step;
  logic [31:0] wbus;
  logic [31:0] rdata_next;
  logic [7:0] pick;
  logic [1:0] pos;
  logic [2:0] nbytes;
  logic [1:0] rd_pos;
  logic take;
  logic beat_done;

  // --------------------------------
  // endian strap synchroniser
  // --------------------------------
  // left unreset so the strap is through both flops by release
  always_ff @(posedge clock) begin
    if (clock_en) begin
      strap_sync_reg <= {strap_sync_reg[0], endian_select_pin};
    end
  end

  // --------------------------------
  // endian strap capture
  // --------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strap_taken_reg <= 1'h0;
      big_endian_reg <= ELSB_ENDIAN_RESET;
    end else if (clock_en) begin
      if (!strap_taken_reg) begin
        strap_taken_reg <= 1'h1; // see RQ8
        big_endian_reg <= (strap_sync_reg[1] == ELSB_ENDIAN_BIG);
      end
    end
  end
  assign big_endian = big_endian_reg;

  // --------------------------------
  // handshake decode
  // --------------------------------
  assign take = req_ready && req_valid;
  assign beat_done = ext_valid && ext_ready;

  elsb_lane_map u_map (
    .size(req_reg.size),
    .dwidth(req_reg.dwidth),
    .big_endian(big_endian_reg),
    .base_low(req_reg.addr[1:0]),
    .step(step_reg),
    .beat_low(beat_low),
    .strobe(strobe),
    .lane_of_byte0(lane0),
    .pieces_minus1(last_step)
  );

  // --------------------------------
  // byte placement for this beat
  // --------------------------------
  always_comb begin
    nbytes = (req_reg.size == ELSB_SZ_BYTE) ? 3'h1 : (req_reg.size == ELSB_SZ_WORD) ? 3'h2 : 3'h4;
    wbus = 32'h0;
    pos = 2'h0;
    pick = 8'h0;
    for (int l = 0; l < ELSB_LANES; l++) begin
      // byte offset within access carried on lane l
      pos = 2'(beat_low - req_reg.addr[1:0]) + (big_endian_reg ? 2'(lane0 - 2'(l)) : 2'(2'(l) - lane0));
      // big endian: offset 0 is most significant byte; see RQ1 see RQ2 see RQ6
      pick = big_endian_reg ? 8'(req_reg.wdata >> (8 * (nbytes - 3'h1 - 3'(pos)))) :
        8'(req_reg.wdata >> (8 * pos)); // see RQ5 see RQ7
      if (strobe[l]) begin
        wbus[8*l +: 8] = pick;
      end
    end
  end

  // --------------------------------
  // read byte gathering
  // --------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    rd_pos = 2'h0;
    for (int l = 0; l < ELSB_LANES; l++) begin
      // same lane-to-offset mapping as the write side
      rd_pos = 2'(beat_low - req_reg.addr[1:0]) + (big_endian_reg ? 2'(lane0 - 2'(l)) : 2'(2'(l) - lane0));
      if (strobe[l]) begin
        if (big_endian_reg) begin
          rdata_next[8*(nbytes - 3'h1 - 3'(rd_pos)) +: 8] = ext_rdata[8*l +: 8];
        end else begin
          rdata_next[8*rd_pos +: 8] = ext_rdata[8*l +: 8];
        end
      end
    end
  end

  // --------------------------------
  // split sequencing
  // --------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ELSB_IDLE;
    end else if (clock_en) begin
      case (state_reg)
        ELSB_IDLE: begin
          if (take) begin
            state_reg <= ELSB_BUSY;
          end
        end
        ELSB_BUSY: begin
          // last accepted beat ends the transfer
          if (ext_ready && (step_reg == last_step)) begin
            state_reg <= ELSB_DONE;
          end
        end
        ELSB_DONE: begin
          state_reg <= ELSB_IDLE;
        end
        default: begin
          state_reg <= ELSB_IDLE;
        end
      endcase
    end
  end

  // --------------------------------
  // request capture
  // --------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      req_reg <= '0;
    end else if (clock_en && take) begin
      req_reg <= req;
    end
  end

  // --------------------------------
  // beat counter
  // --------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      step_reg <= ELSB_STEP_RESET;
    end else if (clock_en) begin
      // one step per accepted beat, addresses ascend
      if (take) begin
        step_reg <= ELSB_STEP_RESET;
      end else if (beat_done && (step_reg != last_step)) begin
        step_reg <= step_reg + 2'h1; // see RQ9
      end
    end
  end

  // --------------------------------
  // read data assembly
  // --------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 32'h0;
    end else if (clock_en) begin
      if (take) begin
        rdata_reg <= 32'h0;
      end else if (beat_done) begin
        rdata_reg <= rdata_next; // see RQ9
      end
    end
  end

  // --------------------------------
  // outputs
  // --------------------------------
  assign req_ready = (state_reg == ELSB_IDLE) && strap_taken_reg;
  assign ext_valid = (state_reg == ELSB_BUSY);
  assign ext_beat.addr = {req_reg.addr[31:2], beat_low};
  assign ext_beat.write = req_reg.write;
  assign ext_beat.wdata = wbus;
  assign ext_beat.strobe = (state_reg == ELSB_BUSY) ? strobe : 4'h0;
  assign resp_valid = (state_reg == ELSB_DONE); // see RQ9
  assign resp_rdata = rdata_reg;
endmodule

/* File: sim/elsb_mem.sv */
// Purpose: external memory answering lane-placed beats
// Assumes: beats are held until ext_ready
// Notes: read byte is 0xA0 plus the low two bits of the beat address, only on strobed lanes
`timescale 1ns/1ps
module elsb_mem
  import elsb_pkg::*;
(
  // bus side
  input wire logic clock, input wire logic slow,
  input wire logic ext_valid, input wire elsb_beat_t ext_beat,
  output logic ext_ready, output logic [31:0] ext_rdata
);
  logic tick_reg = 1'b0;
  logic [7:0] pat;
  always_ff @(posedge clock) tick_reg <= !tick_reg;
  assign ext_ready = ext_valid && (!slow || tick_reg);
  assign pat = 8'hA0 | {6'h0, ext_beat.addr[1:0]};
  // unstrobed or idle lanes show the inverse so a wrong lane is seen
  always_comb begin
    for (int l = 0; l < 4; l++) ext_rdata[8*l +: 8] = (ext_valid && ext_beat.strobe[l]) ? pat : ~pat;
  end
endmodule

/* File: sim/elsb_core_chk.sv */
// Purpose: port assertions for lane steering
// Assumes: clock_en held high
// Notes: request captured at the take edge
`timescale 1ns/1ps
module elsb_core_chk
  import elsb_pkg::*;
(
  // watched ports
  input wire logic clock, input wire logic rst_b, input wire logic clock_en,
  input wire logic endian_select_pin, input wire logic req_valid, input wire elsb_req_t req,
  input wire logic req_ready, input wire logic resp_valid, input wire logic [31:0] resp_rdata,
  input wire logic ext_valid, input wire elsb_beat_t ext_beat, input wire logic ext_ready,
  input wire logic [31:0] ext_rdata, input wire logic big_endian
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  elsb_req_t cur_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) cur_reg <= '0;
    else if (req_valid && req_ready && clock_en) cur_reg <= req;
  end
  sequence take_s; req_valid && req_ready; endsequence
  sequence done_s; ext_valid && ext_ready; endsequence
  narrow_lane_a:
    assert property (ext_valid && cur_reg.dwidth == ELSB_DW_8 |-> ext_beat.strobe == 4'h1) else $error("narrow strobe");
  half_lane_a:
    assert property (ext_valid && cur_reg.dwidth == ELSB_DW_16 && cur_reg.size != ELSB_SZ_BYTE
      |-> ext_beat.strobe == 4'h3) else $error("half strobe");
  byte_lane_a:
    assert property (ext_valid && cur_reg.size == ELSB_SZ_BYTE |-> $onehot(ext_beat.strobe)) else $error("byte strobe");
  wide_long_a:
    assert property (ext_valid && cur_reg.dwidth == ELSB_DW_32 && cur_reg.size == ELSB_SZ_LONG
      |-> ext_beat.strobe == 4'hF && ext_beat.wdata == cur_reg.wdata) else $error("long beat");
  endian_map_a:
    assert property (req_ready |-> big_endian == !endian_select_pin) else $error("endian mode");
  endian_keep_a:
    assert property (req_ready |=> $stable(big_endian)) else $error("endian moved");
  take_beat_a:
    assert property (take_s |=> ext_valid) else $error("no beat");
  beat_hold_a:
    assert property (ext_valid && !ext_ready |=> ext_valid && $stable(ext_beat)) else $error("beat dropped");
  resp_after_a:
    assert property (resp_valid |-> $past(ext_valid) && $past(ext_ready) && !ext_valid) else $error("early resp");
  half_byte_a:
    assert property (ext_valid && big_endian && cur_reg.dwidth == ELSB_DW_16 && cur_reg.size == ELSB_SZ_BYTE
      |-> ext_beat.strobe == (ext_beat.addr[0] ? 4'h1 : 4'h2)) else $error("half byte lane");
  beat_next_a:
    assert property (done_s |=> ext_valid || resp_valid) else $error("beat lost");
  resp_pulse_a:
    assert property (resp_valid |=> !resp_valid && req_ready) else $error("resp pulse");
endmodule
bind elsb_core elsb_core_chk u_chk (.*);

/* File: sim/elsb_core_test.sv */
// Purpose: self-checking bench for lane steering
// Assumes: clock_en tied high, writes carry 0xA1B2C3D4
// Notes: reset between endian modes
`timescale 1ns/1ps
module elsb_core_test
  import elsb_pkg::*;
;
  logic clock = 1'b0, rst_b = 1'b0, pin = 1'b0, req_valid = 1'b0, slow = 1'b0;
  logic req_ready, resp_valid, ext_valid, ext_ready, be;
  logic [31:0] rdata, ext_rdata;
  elsb_req_t req = '0;
  elsb_beat_t beat;
  elsb_beat_t q[$];
  int n_fail = 0, n_tests = 0;
  always #2 clock = !clock;
  elsb_core u_dut (.clock(clock), .rst_b(rst_b), .clock_en(1'b1), .endian_select_pin(pin), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(rdata), .ext_valid(ext_valid),
    .ext_beat(beat), .ext_ready(ext_ready), .ext_rdata(ext_rdata), .big_endian(be));
  elsb_mem u_mem (.clock(clock), .slow(slow), .ext_valid(ext_valid), .ext_beat(beat), .ext_ready(ext_ready),
    .ext_rdata(ext_rdata));
  always @(posedge clock) if (ext_valid && ext_ready) q.push_back(beat);
  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reboot(input logic p);
    @(negedge clock);
    rst_b = 1'b0;
    pin = p;
    repeat (16) @(negedge clock);
    rst_b = 1'b1;
    repeat (3) @(negedge clock);
    chk(be, !p);
  endtask
  task automatic xfer(input elsb_size_t sz, input elsb_dwidth_t dw, input logic [1:0] a, input logic wr);
    int i;
    q.delete();
    while (req_ready !== 1'b1) @(negedge clock);
    req = '{addr: {30'h0, a}, size: sz, dwidth: dw, write: wr, wdata: 32'hA1B2C3D4};
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    for (i = 0; i < 40 && resp_valid !== 1'b1; i++) @(negedge clock);
    chk(resp_valid, 32'h1);
    foreach (q[k]) chk(q[k].write, wr);
  endtask
  task automatic bt(input int i, input logic [3:0] s, input logic [1:0] a, input logic [31:0] d);
    chk(q[i].strobe, s);
    chk(q[i].addr[1:0], a);
    chk(q[i].wdata & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}}, d);
  endtask
  task automatic s_big_narrow;
    reboot(1'b0);
    xfer(ELSB_SZ_LONG, ELSB_DW_8, 2'h0, 1'b1);
    chk(q.size(), 32'h4);
    for (int i = 0; i < 4; i++) bt(i, 4'h1, 2'(i), 32'(8'(32'hA1B2C3D4 >> (24 - 8 * i))));
    xfer(ELSB_SZ_LONG, ELSB_DW_8, 2'h0, 1'b0);
    chk(rdata, 32'hA0A1A2A3);
    slow = 1'b1;
    xfer(ELSB_SZ_LONG, ELSB_DW_16, 2'h0, 1'b1);
    bt(0, 4'h3, 2'h0, 32'hA1B2);
    bt(1, 4'h3, 2'h2, 32'hC3D4);
    xfer(ELSB_SZ_LONG, ELSB_DW_16, 2'h0, 1'b0);
    chk(rdata, 32'hA0A0A2A2);
    slow = 1'b0;
  endtask
  task automatic s_big_wide;
    xfer(ELSB_SZ_BYTE, ELSB_DW_32, 2'h0, 1'b1);
    bt(0, 4'h8, 2'h0, 32'hD4000000);
    xfer(ELSB_SZ_BYTE, ELSB_DW_32, 2'h3, 1'b1);
    bt(0, 4'h1, 2'h3, 32'hD4);
    xfer(ELSB_SZ_WORD, ELSB_DW_32, 2'h0, 1'b1);
    bt(0, 4'hC, 2'h0, 32'hC3D40000);
    xfer(ELSB_SZ_BYTE, ELSB_DW_16, 2'h0, 1'b1);
    bt(0, 4'h2, 2'h0, 32'hD400);
    xfer(ELSB_SZ_BYTE, ELSB_DW_16, 2'h1, 1'b1);
    bt(0, 4'h1, 2'h1, 32'hD4);
    xfer(ELSB_SZ_WORD, ELSB_DW_16, 2'h2, 1'b1);
    bt(0, 4'h3, 2'h2, 32'hC3D4);
  endtask
  task automatic s_little_wide;
    reboot(1'b1);
    for (int a = 0; a < 4; a++) begin
      xfer(ELSB_SZ_BYTE, ELSB_DW_32, 2'(a), 1'b1);
      bt(0, 4'h1 << a, 2'(a), 32'hD4 << (8 * a));
    end
    xfer(ELSB_SZ_WORD, ELSB_DW_32, 2'h2, 1'b1);
    bt(0, 4'hC, 2'h2, 32'hC3D40000);
    xfer(ELSB_SZ_WORD, ELSB_DW_32, 2'h0, 1'b0);
    chk(rdata, 32'hA0A0);
    xfer(ELSB_SZ_LONG, ELSB_DW_32, 2'h0, 1'b1);
    bt(0, 4'hF, 2'h0, 32'hA1B2C3D4);
    chk(q.size(), 32'h1);
  endtask
  task automatic s_little_narrow;
    xfer(ELSB_SZ_LONG, ELSB_DW_8, 2'h0, 1'b1);
    for (int i = 0; i < 4; i++) bt(i, 4'h1, 2'(i), 32'(8'(32'hA1B2C3D4 >> (8 * i))));
    xfer(ELSB_SZ_WORD, ELSB_DW_8, 2'h2, 1'b0);
    chk(rdata, 32'hA3A2);
  endtask
  task automatic summarize;
    $display("fails %0d tests %0d", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    s_big_narrow();
    s_big_wide();
    s_little_wide();
    s_little_narrow();
    summarize();
  end
  initial begin
    #20000;
    n_fail++;
    summarize();
  end
endmodule
